//--- core/msi2c_regs.vh
`ifndef MSI2C_REGS_VH
`define MSI2C_REGS_VH
// fixed high bits of the slave address
`define MSI2C_ADDR_FIXED   2'h3
// general call address
`define MSI2C_GCALL_ADDR   7'h00
// most data bytes the device accepts in one write transfer
`define MSI2C_MAX_BYTES    4'h8
// highest bit rate in bit/s and the system clock rate in Hz
`define MSI2C_MAX_RATE_BPS 400000
`define MSI2C_CLK_HZ       40000000
// bus-free interval after a stop, in ns, and its cycle count (rounded up)
`define MSI2C_TBUF_NS      1300
`define MSI2C_TBUF_CYC     ((`MSI2C_TBUF_NS * 40 + 999) / 1000)
// spike filter length in ns for the clock, data and strap lines, and its cycle count (rounded down)
`define MSI2C_SPIKE_NS     50
`define MSI2C_SPIKE_CYC    ((`MSI2C_SPIKE_NS * 40) / 1000)
// bit count of a byte
`define MSI2C_BYTE_BITS    4'h8
`endif

//--- core/msi2c_fifo.v
`timescale 1ns/100ps
module msi2c_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // fill side
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  // drain side
  output reg              rd_valid_out,
  input  wire             rd_ready_in,
  output reg  [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      count;
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  wire            do_wr;
  wire            do_rd;
  wire            full;

  assign full         = (count == DEPTH[AW:0]);
  assign wr_ready_out = ~full;
  assign do_wr        = wr_valid_in & ~full;
  // read data sits in a register; a word leaves when the output stage is empty or taken
  assign do_rd        = (count != {(AW+1){1'b0}}) & (~rd_valid_out | rd_ready_in);

  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count        <= {(AW+1){1'b0}};
      wr_ptr       <= {AW{1'b0}};
      rd_ptr       <= {AW{1'b0}};
      rd_valid_out <= 1'b0;
      rd_data_out  <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr       <= rd_ptr + 1'b1;
        rd_data_out  <= mem[rd_ptr];
        rd_valid_out <= 1'b1;
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule // msi2c_fifo

//--- core/msi2c_sync.v
`timescale 1ns/100ps
// three-stage synchroniser; a level change counts once stages two and three agree on it for FILT+1 cycles
module msi2c_sync #(
  parameter FILT = 2
) (
  // clock and reset
  input  wire clk_in,
  input  wire rst_in,
  // line
  input  wire line_in,
  output reg  line_out
);
  reg       s1;
  reg       s2;
  reg       s3;
  reg [3:0] cnt;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1       <= 1'b1;
      s2       <= 1'b1;
      s3       <= 1'b1;
      cnt      <= 4'h0;
      line_out <= 1'b1;
    end else begin
      s1 <= line_in;
      s2 <= s1;
      s3 <= s2;
      // a new level must hold FILT cycles beyond the agreement, so spikes die here
      if (s2 == s3 && s3 != line_out) begin
        if (cnt >= FILT[3:0]) begin
          line_out <= s3;
          cnt      <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule // msi2c_sync

//--- core/msi2c_slave.v
`timescale 1ns/100ps
`include "msi2c_regs.vh"
module msi2c_slave #(
  parameter TBUF_CYC  = `MSI2C_TBUF_CYC,
  parameter SPIKE_CYC = `MSI2C_SPIKE_CYC,
  parameter DEPTH     = 4
) (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_in,
  // serial clock line, open drain
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe_out,
  // serial data line, open drain
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  // address setting
  input  wire [3:0] addr_prog_in,
  input  wire       address_strap_pin_in,
  // received bytes towards the command logic
  output reg        rx_valid_out,
  input  wire       rx_ready_in,
  output reg  [7:0] rx_data_out,
  output reg        rx_first_out,
  output reg        rx_gcall_out,
  // transmit bytes from the command logic
  input  wire [7:0] tx_data_in,
  output reg        tx_take_out,
  // status
  output reg        bus_busy_out,
  output reg        addressed_out,
  output reg        reg_addr_valid_out,
  output reg  [7:0] reg_addr_out
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_AACK  = 3'h2;
  localparam ST_RX    = 3'h3;
  localparam ST_RACK  = 3'h4;
  localparam ST_TX    = 3'h5;
  localparam ST_TACK  = 3'h6;

  wire       scl_s;
  wire       sda_s;
  reg        scl_d;
  reg        sda_d;
  reg  [2:0] state;
  reg  [3:0] bitcnt;
  reg  [7:0] shreg;
  reg  [3:0] nbytes;
  reg        ack_pend;
  reg        gcall;
  reg        first;
  reg  [7:0] tx_sh;
  reg  [15:0] buf_cnt;
  reg        strap;
  wire       strap_s;
  reg        freeing;
  wire       fifo_ready;
  wire       fifo_valid;
  wire [9:0] fifo_data;
  reg        push;
  reg  [9:0] push_data;
  wire       start_ev;
  wire       stop_ev;
  wire       scl_rise;
  wire       scl_fall;
  wire [6:0] own_addr;

  // address match helper
  function addr_hit;
    input [6:0] a;
    input [6:0] own;
    begin
      addr_hit = (a == own) || (a == `MSI2C_GCALL_ADDR);
    end
  endfunction

  msi2c_sync #(.FILT(SPIKE_CYC)) u_scl_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .line_in  (scl_in),
    .line_out (scl_s)
  );
  msi2c_sync #(.FILT(SPIKE_CYC)) u_sda_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .line_in  (sda_in),
    .line_out (sda_s)
  );
  // the strap is a pin too, so it crosses into the clock domain the same way
  msi2c_sync #(.FILT(SPIKE_CYC)) u_strap_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .line_in  (address_strap_pin_in),
    .line_out (strap_s)
  );

  msi2c_fifo #(.WIDTH(10), .DEPTH(DEPTH), .AW(2)) u_fifo (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_valid_in  (push),
    .wr_ready_out (fifo_ready),
    .wr_data_in   (push_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (~rx_valid_out | rx_ready_in),
    .rd_data_out  (fifo_data)
  );

  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev  = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign own_addr = {`MSI2C_ADDR_FIXED, addr_prog_in, strap};

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d              <= 1'b1;
      sda_d              <= 1'b1;
      state              <= ST_IDLE;
      bitcnt             <= 4'h0;
      shreg              <= 8'h00;
      nbytes             <= 4'h0;
      ack_pend           <= 1'b0;
      gcall              <= 1'b0;
      first              <= 1'b0;
      tx_sh              <= 8'h00;
      buf_cnt            <= 16'h0000;
      strap              <= 1'b0;
      freeing            <= 1'b0;
      push               <= 1'b0;
      push_data          <= 10'h000;
      scl_out            <= 1'b0;
      scl_oe_out         <= 1'b0;
      sda_out            <= 1'b0;
      sda_oe_out         <= 1'b0;
      tx_take_out        <= 1'b0;
      bus_busy_out       <= 1'b0;
      addressed_out      <= 1'b0;
      reg_addr_valid_out <= 1'b0;
      reg_addr_out       <= 8'h00;
      rx_valid_out       <= 1'b0;
      rx_data_out        <= 8'h00;
      rx_first_out       <= 1'b0;
      rx_gcall_out       <= 1'b0;
    end else begin
      scl_d       <= scl_s;
      sda_d       <= sda_s;
      push        <= 1'b0;
      tx_take_out <= 1'b0;
      // strap is caught while the state is ST_IDLE, never under reset itself
      if (state == ST_IDLE) begin
        strap <= strap_s;
      end
      if (fifo_valid && (~rx_valid_out | rx_ready_in)) begin
        rx_valid_out <= 1'b1;
        rx_data_out  <= fifo_data[7:0];
        rx_first_out <= fifo_data[8];
        rx_gcall_out <= fifo_data[9];
      end else if (rx_ready_in) begin
        rx_valid_out <= 1'b0;
      end
      // busy from start until the bus-free time after a stop
      // free time counts only after a stop; an unaddressed slave sits idle on a busy bus
      if (start_ev) begin
        bus_busy_out <= 1'b1;
        buf_cnt      <= 16'h0000;
        freeing      <= 1'b0;
      end else if (stop_ev) begin
        freeing <= 1'b1;
        buf_cnt <= 16'h0000;
      end else if (freeing && bus_busy_out) begin
        if (buf_cnt >= TBUF_CYC[15:0]) begin
          bus_busy_out <= 1'b0;
        end else begin
          buf_cnt <= buf_cnt + 16'h0001;
        end
      end
      if (start_ev) begin
        // restart handled exactly as start: partial byte dropped
        state      <= ST_ADDR;
        bitcnt     <= 4'h0;
        nbytes     <= 4'h0;
        sda_oe_out <= 1'b0;
        scl_oe_out <= 1'b0;
        addressed_out <= 1'b0;
      end else if (stop_ev) begin
        state      <= ST_IDLE;
        bitcnt     <= 4'h0;
        sda_oe_out <= 1'b0;
        scl_oe_out <= 1'b0;
        addressed_out <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == `MSI2C_BYTE_BITS) begin
              bitcnt <= 4'h0;
              if (state == ST_ADDR) begin
                state <= ST_AACK;
                if (addr_hit(shreg[7:1], own_addr)) begin
                  sda_oe_out    <= 1'b1;
                  addressed_out <= 1'b1;
                  gcall         <= (shreg[7:1] == `MSI2C_GCALL_ADDR);
                  first         <= 1'b1;
                  nbytes        <= 4'h0;
                end else begin
                  sda_oe_out <= 1'b0;
                end
              end else begin
                state <= ST_RACK;
                // the ninth byte or a full fifo gets no acknowledge
                if (nbytes < `MSI2C_MAX_BYTES && fifo_ready) begin
                  sda_oe_out <= 1'b1;
                  push       <= 1'b1;
                  push_data  <= {gcall, first, shreg};
                  nbytes     <= nbytes + 4'h1;
                  if (first && !gcall) begin
                    reg_addr_out       <= shreg;
                    reg_addr_valid_out <= 1'b1;
                  end
                  first <= 1'b0;
                end else begin
                  sda_oe_out <= 1'b0;
                end
              end
            end
          end
          ST_AACK, ST_RACK: begin
            // acknowledge held through the high phase, released after the fall
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              if (!addressed_out) begin
                state <= ST_IDLE;
              end else if (state == ST_AACK && shreg[0]) begin
                // the byte is taken from tx_data_in at this fall; the clock is not stretched for it
                state       <= ST_TX;
                tx_sh       <= {tx_data_in[6:0], 1'b0};
                tx_take_out <= 1'b1;
                sda_oe_out  <= ~tx_data_in[7];
                bitcnt      <= 4'h1;
              end else begin
                state <= ST_RX;
              end
            end
          end
          ST_TX: begin
            // hold the clock while the received-byte path is full
            scl_oe_out <= ~scl_s & ~fifo_ready;
            if (scl_fall) begin
              if (bitcnt == `MSI2C_BYTE_BITS) begin
                sda_oe_out <= 1'b0;
                state      <= ST_TACK;
                bitcnt     <= 4'h0;
              end else begin
                sda_oe_out <= ~tx_sh[7];
                tx_sh      <= {tx_sh[6:0], 1'b0};
                bitcnt     <= bitcnt + 4'h1;
              end
            end
          end
          ST_TACK: begin
            scl_oe_out <= 1'b0;
            if (scl_rise) begin
              ack_pend <= ~sda_s;
            end
            if (scl_fall) begin
              if (ack_pend) begin
                state       <= ST_TX;
                tx_sh       <= {tx_data_in[6:0], 1'b0};
                tx_take_out <= 1'b1;
                sda_oe_out  <= ~tx_data_in[7];
                bitcnt      <= 4'h1;
              end else begin
                state      <= ST_IDLE;
                sda_oe_out <= 1'b0;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // msi2c_slave

//--- testbench/msi2c_slave_monitor.sv
`timescale 1ns/100ps
module msi2c_slave_monitor #(
  parameter int TBUF_CYC = 4
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_out,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       rx_valid_out,
  input wire logic       rx_ready_in,
  input wire logic [7:0] rx_data_out,
  input wire logic       tx_take_out,
  input wire logic       bus_busy_out
);
  // sync plus filter delay, then the bus-free wait
  localparam int BUSY_MAX = TBUF_CYC + 16;
  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_scl_low_only: assert property (scl_out == 1'b0)
    else $error("clock line driven high");
  chk_sda_low_only: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_sda_moves_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed while clock high");
  chk_stretch_busy: assert property (scl_oe_out |-> bus_busy_out)
    else $error("clock held outside a transfer");
  chk_start_busy: assert property (!bus_busy_out && scl_in && $fell(sda_in)
    |-> ##[1:12] bus_busy_out) else $error("start not seen");
  chk_stop_free: assert property (bus_busy_out && scl_in && $rose(sda_in)
    |-> ##[1:BUSY_MAX] !bus_busy_out) else $error("bus not freed after stop");
  chk_rx_held: assert property (rx_valid_out && !rx_ready_in
    |=> rx_valid_out && $stable(rx_data_out)) else $error("stalled byte lost");
  chk_take_pulse: assert property (tx_take_out |=> !tx_take_out)
    else $error("transmit take longer than one cycle");
  chk_reset_quiet: assert property (disable iff (1'b0) $fell(rst_in)
    |-> !bus_busy_out && !sda_oe_out && !scl_oe_out) else $error("busy after reset");
endmodule // msi2c_slave_monitor

//--- testbench/msi2c_master_model.sv
`timescale 1ns/100ps
module msi2c_master_model (
  // wired line levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // pull-downs of this master
  output logic      scl_low_out,
  output logic      sda_low_out
);
  logic lclk = 1'b0;
  always #100 lclk = ~lclk;
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // release the clock and wait, bounded, while the slave holds it
  task automatic rise();
    int i;
    scl_low_out = 1'b0;
    for (i = 0; i < 400 && scl_in !== 1'b1; i++) @(posedge lclk);
    tick(2);
  endtask
  // data moves a tick after the clock falls, never while it is high
  task automatic bit_io(input logic b, output logic seen);
    tick(1);
    sda_low_out = ~b;
    tick(1);
    rise();
    seen = sda_in;
    scl_low_out = 1'b1;
  endtask
  task automatic start();
    tick(1);
    sda_low_out = 1'b0;
    tick(1);
    rise();
    sda_low_out = 1'b1;
    tick(2);
    scl_low_out = 1'b1;
  endtask
  task automatic stop();
    tick(1);
    sda_low_out = 1'b1;
    tick(1);
    rise();
    sda_low_out = 1'b0;
    tick(4);
  endtask
  // n below eight leaves a partial byte without an acknowledge slot
  task automatic send(input logic [7:0] d, input int n, output logic nack);
    logic s;
    int i;
    for (i = 7; i > 7 - n; i--) bit_io(d[i], s);
    nack = 1'b1;
    if (n == 8) bit_io(1'b1, nack);
  endtask
  task automatic recv(input logic nack, output logic [7:0] d);
    logic s;
    int i;
    for (i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
endmodule // msi2c_master_model

//--- testbench/msi2c_slave_test.sv
`timescale 1ns/100ps
module msi2c_slave_test;
  localparam int TBUF = 4;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       rx_ready = 1'b1;
  logic       strap = 1'b1;
  logic [7:0] tx_data = 8'h3c;
  wire        m_scl, m_sda, scl_oe, sda_oe, rx_valid, rx_first, rx_gcall;
  wire        take, busy, addressed, ra_valid;
  wire  [7:0] rx_data, reg_addr;
  wire        scl = ~(m_scl | scl_oe);
  wire        sda = ~(m_sda | sda_oe);
  int         fails = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         takes = 0;
  int         held = 0;
  logic [9:0] q[$];
  // address byte and expected acknowledge level; own address is 7'h6b
  logic [8:0] rows[4] = '{{8'hd6, 1'b0}, {8'hd4, 1'b1}, {8'h00, 1'b0}, {8'h56, 1'b1}};
  always #12.5 clk_in = ~clk_in;
  msi2c_master_model m (.scl_in(scl), .sda_in(sda), .scl_low_out(m_scl), .sda_low_out(m_sda));
  msi2c_slave #(.TBUF_CYC(TBUF), .SPIKE_CYC(2), .DEPTH(4)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .addr_prog_in(4'h5),
    .address_strap_pin_in(strap), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .rx_data_out(rx_data), .rx_first_out(rx_first), .rx_gcall_out(rx_gcall),
    .tx_data_in(tx_data), .tx_take_out(take), .bus_busy_out(busy),
    .addressed_out(addressed), .reg_addr_valid_out(ra_valid), .reg_addr_out(reg_addr));
  always @(posedge clk_in) begin
    if (rx_valid && rx_ready) q.push_back({rx_gcall, rx_first, rx_data});
    if (take) takes++;
    if (scl_oe) held++;
    cyc++;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (30) @(posedge clk_in);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    logic       n;
    logic [8:0] v;
    logic [7:0] d;
    int         i, k;
    repeat (6) @(posedge clk_in);
    check({busy, sda_oe, scl_oe, rx_valid}, 4'h0);
    #2 rst_in = 1'b0;
    repeat (6) @(posedge clk_in);
    for (i = 0; i < 4; i++) begin
      m.start();
      m.send(rows[i][8:1], 8, n);
      check(n, rows[i][0]);
      check(addressed, !rows[i][0]);
      for (k = 0; k < 2 && !n; k++) m.send(8'ha0 + 8'(i) + 8'(k), 8, n);
      m.stop();
      settle();
      check(busy, 1'b0);
      check(16'(q.size()), rows[i][0] ? 16'h0 : 16'h2);
      if (q.size() == 2) begin
        check(q[0], {rows[i][8:1] == 8'h00, 1'b1, 8'ha0 + 8'(i)});
        check(q[1], {rows[i][8:1] == 8'h00, 1'b0, 8'ha1 + 8'(i)});
      end
      q.delete();
    end
    m.start();
    m.send(8'hd6, 8, n);
    for (k = 0; k < 9; k++) m.send(8'h10 + 8'(k), 8, v[k]);
    m.stop();
    settle();
    check(v, 9'h100);
    check(16'(q.size()), 16'h8);
    check({ra_valid, reg_addr}, {1'b1, 8'h10});
    q.delete();
    rx_ready = 1'b0;
    m.start();
    m.send(8'hd6, 8, n);
    for (k = 0; k < 8 && !n; k++) m.send(8'h40 + 8'(k), 8, n);
    check(k - 1 >= 4, 1'b1);
    check(n, 1'b1);
    // read with the received path still full: the clock is held until it drains
    m.start();
    m.send(8'hd7, 8, n);
    check(n, 1'b0);
    fork
      m.recv(1'b1, d);
      begin
        repeat (100) @(posedge clk_in);
        #2 rx_ready = 1'b1;
      end
    join
    check(d, tx_data);
    check(held > 20, 1'b1);
    m.stop();
    settle();
    check(16'(q.size()), 16'(k - 1));
    q.delete();
    m.start();
    m.send(8'hd6, 8, n);
    m.send(8'h05, 8, n);
    m.start();
    check(busy, 1'b1);
    m.send(8'hd7, 8, n);
    check(n, 1'b0);
    m.recv(1'b0, d);
    check(d, tx_data);
    m.recv(1'b1, d);
    check(d, tx_data);
    repeat (12) @(posedge clk_in);
    check(sda_oe, 1'b0);
    m.stop();
    settle();
    check({ra_valid, reg_addr}, {1'b1, 8'h05});
    check(16'(takes), 16'h3);
    m.start();
    m.send(8'hd6, 4, n);
    m.start();
    m.send(8'hd6, 8, n);
    check(n, 1'b0);
    // reset in the middle of a transfer, then a fresh address must work
    @(posedge clk_in);
    #2 rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    check({busy, addressed, sda_oe, ra_valid}, 4'h0);
    #2 rst_in = 1'b0;
    m.stop();
    settle();
    m.start();
    m.send(8'hd6, 8, n);
    check({n, addressed}, 2'h1);
    m.stop();
    settle();
    check(busy, 1'b0);
    stop_test();
  end
endmodule // msi2c_slave_test
bind msi2c_slave msi2c_slave_monitor #(.TBUF_CYC(TBUF_CYC)) mon_u (
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in), .rx_data_out(rx_data_out),
  .tx_take_out(tx_take_out), .bus_busy_out(bus_busy_out));
